// ---- core/fcmd_map.svh ----
// Register offsets, field positions, status words and parameter codes
// for the file access command unit. Definitions only.
`ifndef FCMD_MAP_SVH
`define FCMD_MAP_SVH

// Register offsets on the 8-bit register port
`define REG_CMD        8'h00
`define REG_PARAM      8'h04
`define REG_CURSEL     8'h08
`define REG_RESULT     8'h0C
`define REG_FILE_BASE  8'h20

// Field positions
`define CMD_OP_LSB     0
`define PARAM_P1_LSB   0
`define PARAM_P2_LSB   8
`define PARAM_LEN_LSB  16
`define PARAM_ABS_BIT  24
`define RES_PTR_LSB    16
`define RES_SET_BIT    24

// Status words returned to the terminal
`define SW_OK          16'h9000
`define SW_BAD_P1P2    16'h6A86
`define SW_NO_ACCESS   16'h6982
`define SW_NO_RECORD   16'h6A83
`define SW_NO_FILE     16'h6A82
`define SW_BAD_STRUCT  16'h6981

// Status command parameter codes
`define STS_P1_NONE    8'h00
`define STS_P1_INIT    8'h01
`define STS_P1_TERM    8'h02
`define STS_P2_SELECT  8'h00
`define STS_P2_DFNAME  8'h01
`define STS_P2_NODATA  8'h0C

// Record read modes and selector codes
`define REC_MODE_NEXT  3'h2
`define REC_MODE_PREV  3'h3
`define REC_MODE_ABS   3'h4
`define SFI_CURRENT    5'h00
`define SFI_RESERVED   5'h1F
`define BIN_SFI_TAG    3'h4
`define REC_CURRENT    8'h00
`define REC_FIRST      8'h01

// Sizes and reset values
`define FILE_COUNT     4
`define FILE_ENT_RESET 32'h0000_0000
`define WORD_ZERO      32'h0000_0000

`endif

// ---- core/fcmd_pkg.sv ----
// Types shared by the file access command unit and its surroundings.
// Assumes the offsets and codes of fcmd_map.svh.
package fcmd_pkg;

   typedef enum logic [1:0] {
      CMD_STATUS,
      CMD_READ_BIN,
      CMD_UPDATE_BIN,
      CMD_READ_REC
   } cmd_t;

   typedef enum logic [1:0] {
      FT_TRANSPARENT,
      FT_LINEAR,
      FT_CYCLIC,
      FT_NONE
   } file_type_t;

   // One file table word as software writes it
   typedef struct packed {
      logic [5:0]  nrec;
      logic        update_ok;
      logic        read_ok;
      file_type_t  ftype;
      logic        sfi_present;
      logic [4:0]  short_file_id;
      logic [15:0] fid;
   } file_ent_t;

   typedef enum logic [2:0] {
      ACC_NONE,
      ACC_SELECT_RESP,
      ACC_DF_NAME,
      ACC_READ_BIN,
      ACC_UPDATE_BIN,
      ACC_READ_REC
   } access_kind_t;

   // Order handed to the file store
   typedef struct packed {
      access_kind_t kind;
      logic [3:0]   file_idx;
      logic [14:0]  offset;
      logic [7:0]   length;
      logic         length_absent;
      logic [7:0]   record;
   } access_t;

   typedef enum logic [1:0] {
      IND_NONE,
      IND_INIT,
      IND_TERM
   } app_ind_t;

endpackage : fcmd_pkg

// ---- core/file_cmd_unit.sv ----
// File access command unit: decodes status, transparent read/update and
// record read commands, keeps the record pointer of the current file.
// Assumes software loads the file table and parameters before the command
// word, and that an outside file store serves the emitted access orders.
`timescale 1ns/100ps
`default_nettype none
`include "fcmd_map.svh"

module file_cmd_unit #(
   parameter int NUM_FILES = `FILE_COUNT
) (
   // Clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RSTN,
   // Register port
   input  wire logic [7:0]        ADDR,
   input  wire logic [31:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [31:0]       RDATA,
   // File store orders
   output logic                   ACC_VALID,
   output fcmd_pkg::access_t      ACC,
   // Application status indication
   output logic                   IND_VALID,
   output fcmd_pkg::app_ind_t     IND
);

   localparam int IDX_W = $clog2(NUM_FILES);

   fcmd_pkg::file_ent_t file_tab_reg  [NUM_FILES];
   fcmd_pkg::file_ent_t file_tab_next [NUM_FILES];
   logic [7:0]          p1_reg,  p1_next;
   logic [7:0]          p2_reg,  p2_next;
   logic [7:0]          len_reg, len_next;
   logic                labs_reg, labs_next;
   logic [IDX_W-1:0]    cur_reg, cur_next;
   logic [7:0]          ptr_reg, ptr_next;
   logic                pset_reg, pset_next;
   logic [15:0]         sw_reg, sw_next;
   logic                accv_reg, accv_next;
   fcmd_pkg::access_t   acc_reg, acc_next;
   logic                indv_reg, indv_next;
   fcmd_pkg::app_ind_t  ind_reg, ind_next;
   logic [31:0]         rdata_reg, rdata_next;

   // Short id lookup over the file table; first match wins
   function automatic logic [IDX_W:0] find_sfi(input logic [4:0] short_file_id);
      logic             hit;
      logic [IDX_W-1:0] idx;
      logic [4:0]       eff;
      hit = 1'b0;
      idx = '0;
      for (int i = 0; i < NUM_FILES; i++) begin
         eff = file_tab_reg[i].sfi_present ? file_tab_reg[i].short_file_id
                                           : file_tab_reg[i].fid[4:0];
         if (!hit && eff == short_file_id) begin
            hit = 1'b1;
            idx = IDX_W'(i);
         end
      end
      return {hit, idx};
   endfunction : find_sfi

   // Register file and command execution
   always_comb begin
      logic [IDX_W:0]      look;
      logic [IDX_W-1:0]    tgt;
      logic                ok;
      logic                same;
      logic                tset;
      logic [7:0]          rec;
      logic [7:0]          nrec;
      logic [14:0]         off;
      fcmd_pkg::file_ent_t ent;
      fcmd_pkg::cmd_t      cmd;
      look = '0;
      tgt  = cur_reg;
      ok   = 1'b1;
      same = 1'b1;
      tset = 1'b0;
      rec  = '0;
      nrec = '0;
      off  = '0;
      ent  = file_tab_reg[0];
      cmd  = fcmd_pkg::cmd_t'(WDATA[`CMD_OP_LSB +: 2]);
      file_tab_next = file_tab_reg;
      p1_next   = p1_reg;
      p2_next   = p2_reg;
      len_next  = len_reg;
      labs_next = labs_reg;
      cur_next  = cur_reg;
      ptr_next  = ptr_reg;
      pset_next = pset_reg;
      sw_next   = sw_reg;
      accv_next = 1'b0;
      acc_next  = acc_reg;
      indv_next = 1'b0;
      ind_next  = ind_reg;
      rdata_next = `WORD_ZERO;

      if (WR && ADDR == `REG_PARAM) begin
         p1_next   = WDATA[`PARAM_P1_LSB +: 8];
         p2_next   = WDATA[`PARAM_P2_LSB +: 8];
         len_next  = WDATA[`PARAM_LEN_LSB +: 8];
         labs_next = WDATA[`PARAM_ABS_BIT];
      end

      if (WR && ADDR == `REG_CURSEL) begin
         cur_next  = WDATA[IDX_W-1:0];
         pset_next = 1'b0;
      end

      for (int i = 0; i < NUM_FILES; i++) begin
         if (WR && ADDR == 8'(`REG_FILE_BASE + 4 * i)) begin
            file_tab_next[i] = fcmd_pkg::file_ent_t'(WDATA);
         end
      end

      if (WR && ADDR == `REG_CMD) begin
         acc_next = '0;
         acc_next.length        = len_reg;
         acc_next.length_absent = labs_reg;
         unique case (cmd)
            fcmd_pkg::CMD_STATUS: begin
               ok = (p1_reg == `STS_P1_NONE || p1_reg == `STS_P1_INIT
                     || p1_reg == `STS_P1_TERM);
               if (p2_reg == `STS_P2_SELECT) begin
                  acc_next.kind = fcmd_pkg::ACC_SELECT_RESP;
               end else if (p2_reg == `STS_P2_DFNAME) begin
                  acc_next.kind = fcmd_pkg::ACC_DF_NAME;
               end else if (p2_reg == `STS_P2_NODATA) begin
                  acc_next.kind = fcmd_pkg::ACC_NONE;
               end else begin
                  ok = 1'b0;
               end
               if (ok) begin
                  indv_next = 1'b1;
                  ind_next  = fcmd_pkg::app_ind_t'(p1_reg[1:0]);
                  accv_next = (acc_next.kind != fcmd_pkg::ACC_NONE);
                  sw_next   = `SW_OK;
               end else begin
                  sw_next = `SW_BAD_P1P2;
               end
            end
            fcmd_pkg::CMD_READ_BIN, fcmd_pkg::CMD_UPDATE_BIN: begin
               // Same decode for both directions
               if (!p1_reg[7]) begin
                  off = {p1_reg[6:0], p2_reg};
               end else if (p1_reg[7:5] == `BIN_SFI_TAG) begin
                  look = find_sfi(p1_reg[4:0]);
                  off  = {7'h00, p2_reg};
                  tgt  = look[IDX_W-1:0];
                  same = (tgt == cur_reg);
                  if (!look[IDX_W]) begin
                     ok      = 1'b0;
                     sw_next = `SW_NO_FILE;
                  end
               end else begin
                  ok      = 1'b0;
                  sw_next = `SW_BAD_P1P2;
               end
               ent = file_tab_reg[tgt];
               if (ok && ent.ftype != fcmd_pkg::FT_TRANSPARENT) begin
                  ok      = 1'b0;
                  sw_next = `SW_BAD_STRUCT;
               end
               if (ok && cmd == fcmd_pkg::CMD_READ_BIN && !ent.read_ok) begin
                  ok      = 1'b0;
                  sw_next = `SW_NO_ACCESS;
               end
               if (ok && cmd == fcmd_pkg::CMD_UPDATE_BIN && !ent.update_ok) begin
                  ok      = 1'b0;
                  sw_next = `SW_NO_ACCESS;
               end
               if (ok) begin
                  // Length passes through untouched: Le for read, Lc for update
                  acc_next.kind = (cmd == fcmd_pkg::CMD_READ_BIN)
                                  ? fcmd_pkg::ACC_READ_BIN
                                  : fcmd_pkg::ACC_UPDATE_BIN;
                  acc_next.offset   = off;
                  acc_next.file_idx = 4'(tgt);
                  accv_next = 1'b1;
                  sw_next   = `SW_OK;
                  cur_next  = tgt;
                  if (!same) begin
                     pset_next = 1'b0;
                  end
               end
            end
            fcmd_pkg::CMD_READ_REC: begin
               if (p2_reg[7:3] == `SFI_RESERVED) begin
                  ok      = 1'b0;
                  sw_next = `SW_BAD_P1P2;
               end else if (p2_reg[7:3] != `SFI_CURRENT) begin
                  look = find_sfi(p2_reg[7:3]);
                  tgt  = look[IDX_W-1:0];
                  same = (tgt == cur_reg);
                  if (!look[IDX_W]) begin
                     ok      = 1'b0;
                     sw_next = `SW_NO_FILE;
                  end
               end
               ent  = file_tab_reg[tgt];
               nrec = {2'b00, ent.nrec};
               // Another file's pointer counts as never set
               tset = same && pset_reg;
               rec  = ptr_reg;
               if (ok && ent.ftype != fcmd_pkg::FT_LINEAR
                      && ent.ftype != fcmd_pkg::FT_CYCLIC) begin
                  ok      = 1'b0;
                  sw_next = `SW_BAD_STRUCT;
               end
               if (ok && !ent.read_ok) begin
                  ok      = 1'b0;
                  sw_next = `SW_NO_ACCESS;
               end
               if (ok) begin
                  // Preset so a stale result word cannot survive a miss
                  sw_next = `SW_NO_RECORD;
                  // P1 is ignored in next and previous modes
                  unique case (p2_reg[2:0])
                     `REC_MODE_NEXT: begin
                        if (!tset) begin
                           rec = `REC_FIRST;
                        end else if (ptr_reg >= nrec) begin
                           if (ent.ftype == fcmd_pkg::FT_CYCLIC) begin
                              rec = `REC_FIRST;
                           end else begin
                              ok = 1'b0;
                           end
                        end else begin
                           rec = ptr_reg + 8'h01;
                        end
                     end
                     `REC_MODE_PREV: begin
                        if (!tset) begin
                           rec = nrec;
                        end else if (ptr_reg <= `REC_FIRST) begin
                           if (ent.ftype == fcmd_pkg::FT_CYCLIC) begin
                              rec = nrec;
                           end else begin
                              ok = 1'b0;
                           end
                        end else begin
                           rec = ptr_reg - 8'h01;
                        end
                     end
                     `REC_MODE_ABS: begin
                        if (p1_reg == `REC_CURRENT) begin
                           ok = tset;
                        end else begin
                           rec = p1_reg;
                        end
                     end
                     default: begin
                        ok      = 1'b0;
                        sw_next = `SW_BAD_P1P2;
                     end
                  endcase
                  if (ok && (rec == 8'h00 || rec > nrec)) begin
                     ok = 1'b0;
                  end
               end
               if (ok) begin
                  acc_next.kind     = fcmd_pkg::ACC_READ_REC;
                  acc_next.file_idx = 4'(tgt);
                  acc_next.record   = rec;
                  accv_next = 1'b1;
                  sw_next   = `SW_OK;
                  cur_next  = tgt;
                  if (p2_reg[2:0] != `REC_MODE_ABS) begin
                     ptr_next  = rec;
                     pset_next = 1'b1;
                  end else if (!same) begin
                     pset_next = 1'b0;
                  end
               end
               // A failed read leaves ptr_next and pset_next as they were
            end
         endcase
      end

      if (RD) begin
         if (ADDR == `REG_PARAM) begin
            rdata_next = {7'h00, labs_reg, len_reg, p2_reg, p1_reg};
         end else if (ADDR == `REG_CURSEL) begin
            rdata_next = 32'(cur_reg);
         end else if (ADDR == `REG_RESULT) begin
            rdata_next = {7'h00, pset_reg, ptr_reg, sw_reg};
         end
         for (int i = 0; i < NUM_FILES; i++) begin
            if (ADDR == 8'(`REG_FILE_BASE + 4 * i)) begin
               rdata_next = file_tab_reg[i];
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_FILES; i++) begin
            file_tab_reg[i] <= fcmd_pkg::file_ent_t'(`FILE_ENT_RESET);
         end
         p1_reg    <= 8'h00;
         p2_reg    <= 8'h00;
         len_reg   <= 8'h00;
         labs_reg  <= 1'b0;
         cur_reg   <= '0;
         ptr_reg   <= 8'h00;
         pset_reg  <= 1'b0;
         sw_reg    <= `SW_OK;
         accv_reg  <= 1'b0;
         acc_reg   <= '0;
         indv_reg  <= 1'b0;
         ind_reg   <= fcmd_pkg::IND_NONE;
         rdata_reg <= `WORD_ZERO;
      end else begin
         file_tab_reg <= file_tab_next;
         p1_reg    <= p1_next;
         p2_reg    <= p2_next;
         len_reg   <= len_next;
         labs_reg  <= labs_next;
         cur_reg   <= cur_next;
         ptr_reg   <= ptr_next;
         pset_reg  <= pset_next;
         sw_reg    <= sw_next;
         accv_reg  <= accv_next;
         acc_reg   <= acc_next;
         indv_reg  <= indv_next;
         ind_reg   <= ind_next;
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA     = rdata_reg;
   assign ACC_VALID = accv_reg;
   assign ACC       = acc_reg;
   assign IND_VALID = indv_reg;
   assign IND       = ind_reg;

endmodule : file_cmd_unit

`default_nettype wire

// ---- sim/fcmd_checker.sv ----
// Port-level checks for the file access command unit.
// Assumes a bind onto file_cmd_unit; PARAM is shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
`include "fcmd_map.svh"
module fcmd_checker #(
   parameter int NUM_FILES = `FILE_COUNT
) (
   // Clock and reset
   input wire logic               CORE_CLK,
   input wire logic               RSTN,
   // Register port
   input wire logic [7:0]         ADDR,
   input wire logic [31:0]        WDATA,
   input wire logic               WR,
   input wire logic               RD,
   input wire logic [31:0]        RDATA,
   // Orders and indication
   input wire logic               ACC_VALID,
   input wire fcmd_pkg::access_t  ACC,
   input wire logic               IND_VALID,
   input wire fcmd_pkg::app_ind_t IND
);
   logic [31:0] par_reg;
   logic [31:0] par_next;
   logic [7:0]  p1;
   logic [7:0]  p2;
   logic        go;
   logic [1:0]  op;
   logic        p2ok;
   assign p1 = par_reg[7:0];
   assign p2 = par_reg[15:8];
   assign go = WR && ADDR == `REG_CMD;
   assign op = WDATA[1:0];
   assign p2ok = p2 == 8'h00 || p2 == 8'h01 || p2 == `STS_P2_NODATA;
   always_comb begin
      par_next = par_reg;
      if (WR && ADDR == `REG_PARAM)
         par_next = WDATA;
   end
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN)
         par_reg <= `WORD_ZERO;
      else
         par_reg <= par_next;
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   property p_acc_cause;
      ACC_VALID |-> $past(go);
   endproperty
   a_acc_cause: assert property (p_acc_cause) else $error("order without command");
   property p_ind_cause;
      IND_VALID |-> $past(go && op == 2'd0);
   endproperty
   a_ind_cause: assert property (p_ind_cause) else $error("stray indication");
   property p_sts_ind;
      go && op == 2'd0 && p1 <= 8'h02 && p2ok |=> IND_VALID && IND == p1[1:0];
   endproperty
   a_sts_ind: assert property (p_sts_ind) else $error("indication wrong");
   property p_sts_nodata;
      go && op == 2'd0 && (p2 == `STS_P2_NODATA || !p2ok) |=> !ACC_VALID;
   endproperty
   a_sts_nodata: assert property (p_sts_nodata) else $error("status order issued");
   property p_bin_off;
      ACC_VALID && ACC.kind inside {fcmd_pkg::ACC_READ_BIN, fcmd_pkg::ACC_UPDATE_BIN}
         |-> ACC.offset == (p1[7] ? {7'h00, p2} : {p1[6:0], p2});
   endproperty
   a_bin_off: assert property (p_bin_off) else $error("offset wrong");
   property p_bin_len;
      ACC_VALID && ACC.kind == fcmd_pkg::ACC_READ_BIN
         |-> ACC.length == par_reg[23:16] && ACC.length_absent == par_reg[24];
   endproperty
   a_bin_len: assert property (p_bin_len) else $error("read length wrong");
   property p_upd_len;
      ACC_VALID && ACC.kind == fcmd_pkg::ACC_UPDATE_BIN |-> ACC.length == par_reg[23:16];
   endproperty
   a_upd_len: assert property (p_upd_len) else $error("update length wrong");
   property p_bin_rsv;
      go && (op == 2'd1 || op == 2'd2) && p1[7] && p1[6:5] != 2'b00 |=> !ACC_VALID;
   endproperty
   a_bin_rsv: assert property (p_bin_rsv) else $error("reserved offset used");
   property p_rec_mode;
      go && op == 2'd3 && !(p2[2:0] inside {3'h2, 3'h3, 3'h4}) |=> !ACC_VALID;
   endproperty
   a_rec_mode: assert property (p_rec_mode) else $error("reserved mode used");
   property p_rec_abs;
      ACC_VALID && ACC.kind == fcmd_pkg::ACC_READ_REC && p2[2:0] == `REC_MODE_ABS && p1 != 8'h00
         |-> ACC.record == p1;
   endproperty
   a_rec_abs: assert property (p_rec_abs) else $error("absolute record wrong");
   c_rec: cover property (ACC_VALID && ACC.kind == fcmd_pkg::ACC_READ_REC);
   c_upd: cover property (ACC_VALID && ACC.kind == fcmd_pkg::ACC_UPDATE_BIN);
   c_ind: cover property (IND_VALID && IND == fcmd_pkg::IND_TERM);
endmodule : fcmd_checker
`default_nettype wire

// ---- sim/file_store_model.sv ----
// File store stand-in: takes each access order the unit emits.
// Assumes orders arrive as one-cycle ACC_VALID pulses.
`timescale 1ns/100ps
`default_nettype none
module file_store_model (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // Orders from the unit
   input  wire logic              acc_valid,
   input  wire fcmd_pkg::access_t acc,
   // Bookkeeping for the bench
   output var  int                n_ord,
   output var  fcmd_pkg::access_t last_acc
);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         n_ord <= 0;
         last_acc <= '0;
      end else if (acc_valid) begin
         n_ord <= n_ord + 1;
         last_acc <= acc;
      end
   end
endmodule : file_store_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the file access command unit.
// Assumes the checker and file store model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "fcmd_map.svh"
module testbench;
   logic               CORE_CLK = 1'b0;
   logic               RSTN = 1'b0;
   logic [7:0]         ADDR = 8'h00;
   logic [31:0]        WDATA = 32'h0000_0000;
   logic               WR = 1'b0;
   logic               RD = 1'b0;
   logic [31:0]        RDATA;
   logic               ACC_VALID;
   fcmd_pkg::access_t  ACC;
   logic               IND_VALID;
   fcmd_pkg::app_ind_t IND;
   fcmd_pkg::access_t  last_acc;
   int                 n_ord;
   int                 error_cnt = 0;
   int                 compares = 0;
   int                 n0;
   logic [7:0]         p1;
   logic [7:0]         p2;
   logic [7:0]         ln = 8'h00;
   logic               ab = 1'b0;
   logic [31:0]        r;
   always #12.5 CORE_CLK = ~CORE_CLK;
   file_cmd_unit dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .ACC_VALID(ACC_VALID), .ACC(ACC),
      .IND_VALID(IND_VALID), .IND(IND));
   file_store_model fs (.core_clk(CORE_CLK), .rstn(RSTN), .acc_valid(ACC_VALID),
      .acc(ACC), .n_ord(n_ord), .last_acc(last_acc));
   task automatic chk(input bit ok, input string m);
      compares++;
      if (!ok) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd
   function automatic logic [14:0] offs(input logic [7:0] a, input logic [7:0] b);
      return a[7] ? {7'h00, b} : {a[6:0], b};
   endfunction : offs
   // Table word: sfi is {object present, id}, rw is {update, read}
   function automatic logic [31:0] ent(input logic [15:0] fid, input logic [5:0] short_file_id,
      input logic [1:0] ft, input logic [1:0] rw, input logic [5:0] nr);
      return {nr, rw, ft, short_file_id, fid};
   endfunction : ent
   task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b,
      input logic [15:0] sw, input logic [7:0] rec, input logic [7:0] ptr);
      bit acc;
      fcmd_pkg::access_kind_t kd;
      acc = (sw === `SW_OK) && !(op == 2'd0 && b == `STS_P2_NODATA);
      kd = (op == 2'd1) ? fcmd_pkg::ACC_READ_BIN : fcmd_pkg::ACC_READ_REC;
      if (op == 2'd0)
         kd = (b == 8'h00) ? fcmd_pkg::ACC_SELECT_RESP : fcmd_pkg::ACC_DF_NAME;
      if (op == 2'd2)
         kd = fcmd_pkg::ACC_UPDATE_BIN;
      n0 = n_ord;
      wr(`REG_PARAM, {7'h00, ab, ln, b, a});
      wr(`REG_CMD, {30'h0000_0000, op});
      rd(`REG_RESULT, r);
      chk(r[15:0] === sw, "status word");
      chk((n_ord - n0) == int'(acc), "order count");
      if (acc)
         chk(last_acc.kind === kd, "order kind");
      if (acc && (op == 2'd1 || op == 2'd2))
         chk(last_acc.offset === offs(a, b) && last_acc.length === ln, "offset or length");
      if (acc && op == 2'd1)
         chk(last_acc.length_absent === ab, "length absent flag");
      if (acc && op == 2'd3)
         chk(last_acc.record === rec, "record number");
      if (op == 2'd3)
         chk(r[23:16] === ptr && r[24] === (ptr != 8'h00), "record pointer");
      if (op == 2'd0 && sw === `SW_OK)
         chk(IND === a[1:0], "indication");
   endtask : cmd
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   initial begin
      #(25 * 4000);
      error_cnt++;
      final_report();
   end
   initial begin
      void'($urandom(78));
      repeat (12) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      rd(8'h40, r);
      chk(r === 32'h0000_0000, "unmapped read");
      wr(`REG_FILE_BASE, ent(16'h2F05, 6'h00, 2'd0, 2'd3, 6'd0));
      wr(`REG_FILE_BASE + 8'h04, ent(16'h6F01, 6'h00, 2'd1, 2'd1, 6'd3));
      wr(`REG_FILE_BASE + 8'h08, ent(16'h6F02, 6'h27, 2'd2, 2'd1, 6'd3));
      wr(`REG_FILE_BASE + 8'h0C, ent(16'h6F03, 6'h00, 2'd0, 2'd0, 6'd8));
      rd(`REG_FILE_BASE + 8'h08, r);
      chk(r === ent(16'h6F02, 6'h27, 2'd2, 2'd1, 6'd3), "table readback");
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            p2 = (j == 3) ? 8'h02 : (j == 2) ? `STS_P2_NODATA : 8'(j);
            ab = j[0];
            ln = j[1] ? 8'(i + 8) : 8'h00;
            cmd(2'd0, 8'(i), p2, (i == 3 || j == 3) ? `SW_BAD_P1P2 : `SW_OK, 0, 0);
         end
      end
      wr(`REG_CURSEL, 32'h0000_0000);
      for (int k = 0; k < 10; k++) begin
         p1 = 8'($urandom);
         p2 = 8'($urandom);
         ln = 8'($urandom);
         ab = 1'b0;
         if (p1[7])
            p1 = 8'h85;
         cmd(k[0] ? 2'd2 : 2'd1, p1, p2, `SW_OK, 0, 0);
      end
      cmd(2'd1, 8'hA0, 8'h10, `SW_BAD_P1P2, 0, 0);
      cmd(2'd2, 8'hC1, 8'h10, `SW_BAD_P1P2, 0, 0);
      cmd(2'd1, 8'h9E, 8'h00, `SW_NO_FILE, 0, 0);
      cmd(2'd1, 8'h81, 8'h00, `SW_BAD_STRUCT, 0, 0);
      wr(`REG_CURSEL, 32'h0000_0003);
      cmd(2'd1, 8'h00, 8'h02, `SW_NO_ACCESS, 0, 0);
      cmd(2'd2, 8'h00, 8'h02, `SW_NO_ACCESS, 0, 0);
      wr(`REG_CURSEL, 32'h0000_0001);
      cmd(2'd3, 8'h00, 8'h04, `SW_NO_RECORD, 0, 0);
      cmd(2'd3, 8'h00, 8'h02, `SW_OK, 1, 1);
      cmd(2'd3, 8'h00, 8'h02, `SW_OK, 2, 2);
      cmd(2'd3, 8'h00, 8'h02, `SW_OK, 3, 3);
      cmd(2'd3, 8'h00, 8'h02, `SW_NO_RECORD, 0, 3);
      cmd(2'd3, 8'h02, 8'h04, `SW_OK, 2, 3);
      cmd(2'd3, 8'h00, 8'h04, `SW_OK, 3, 3);
      cmd(2'd3, 8'h04, 8'h04, `SW_NO_RECORD, 0, 3);
      cmd(2'd3, 8'h00, 8'h03, `SW_OK, 2, 2);
      cmd(2'd3, 8'h00, 8'h03, `SW_OK, 1, 1);
      cmd(2'd3, 8'h00, 8'h03, `SW_NO_RECORD, 0, 1);
      cmd(2'd3, 8'h00, 8'h01, `SW_BAD_P1P2, 0, 1);
      cmd(2'd3, 8'h00, 8'hFA, `SW_BAD_P1P2, 0, 1);
      cmd(2'd3, 8'h00, 8'h03, `SW_NO_RECORD, 0, 1);
      wr(`REG_CURSEL, 32'h0000_0001);
      cmd(2'd3, 8'h00, 8'h03, `SW_OK, 3, 3);
      cmd(2'd3, 8'h00, 8'h3A, `SW_OK, 1, 1);
      cmd(2'd3, 8'h00, 8'h3B, `SW_OK, 3, 3);
      cmd(2'd3, 8'h00, 8'h3A, `SW_OK, 1, 1);
      cmd(2'd3, 8'h00, 8'h0A, `SW_OK, 1, 1);
      final_report();
   end
endmodule : testbench
bind file_cmd_unit fcmd_checker #(.NUM_FILES(NUM_FILES)) u_chk (.CORE_CLK(CORE_CLK),
   .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .ACC_VALID(ACC_VALID), .ACC(ACC), .IND_VALID(IND_VALID), .IND(IND));
`default_nettype wire
